//--- inc/i2c_status_pkg.sv
`default_nettype none
package i2c_status_pkg;
  // Register byte offsets on the AXI4-Lite port.
  localparam logic [7:0] OFS_STATUS     = 8'h00;
  localparam logic [7:0] OFS_RX_DATA    = 8'h04;
  localparam logic [7:0] OFS_TX_DATA    = 8'h08;
  localparam logic [7:0] OFS_CONFIG     = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;

  // Field positions, shared by status, interrupt status and mask.
  localparam int unsigned BIT_ID_LO  = 11;
  localparam int unsigned BIT_STOP   = 10;
  localparam int unsigned BIT_GC_LO  = 8;
  localparam int unsigned BIT_GC_IRQ = 7;
  localparam int unsigned BIT_BUSY   = 6;
  localparam int unsigned BIT_NACK   = 5;
  localparam int unsigned BIT_RX_OVF = 4;
  localparam int unsigned BIT_RX_IRQ = 3;
  localparam int unsigned BIT_TX_IRQ = 2;
  localparam int unsigned BIT_TX_UNF = 1;

  // Self-clearing command bits of the port configuration register.
  localparam int unsigned CFG_GC_CLEAR = 8;
  localparam int unsigned CFG_RX_FLUSH = 9;
  localparam logic [15:0] CFG_STORE_MASK = 16'hfcff;

  // Reset values.
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET   = 16'h0000;
  localparam logic [15:0] PEND_RESET   = 16'h0000;

  // General call type codes.
  localparam logic [1:0] GC_NONE       = 2'h0;
  localparam logic [1:0] GC_RESET_PROG = 2'h1;
  localparam logic [1:0] GC_PROG       = 2'h2;
  localparam logic [1:0] GC_ALT_ID     = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == OFS_STATUS) || (a == OFS_RX_DATA) || (a == OFS_TX_DATA) ||
                  (a == OFS_CONFIG) || (a == OFS_IRQ_MASK) || (a == OFS_IRQ_STATUS);
  endfunction : addr_mapped

  function automatic logic [15:0] merge_strobe(input logic [15:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
    merge_strobe = old;
    if (strb[0]) begin
      merge_strobe[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge_strobe[15:8] = data[15:8];
    end
  endfunction : merge_strobe
endpackage : i2c_status_pkg
`default_nettype wire

//--- src/i2c_slave_status_flags.sv
// What this block does
// - Report which of four slave identifiers matched, codes 00 to 11.
// - Stop after start and address match sets flag; status read clears it.
// - Encode general call type: none, reset+program, program, alternative identifier.
// - Any general call sets its interrupt flag; configuration bit 8 clears it.
// - General call reset returns registers to defaults, except busy, which follows activity, and the general call type and interrupt flag, which it sets.
// - Hardware general call second byte is pushed into the receive FIFO.
// - Busy flag follows slave activity with no software action.
// - Data request with empty transmit FIFO sets no-ack; status read clears.
// - Receive FIFO overflow sets flag; status read clears it.
// - Received byte sets receive flag; data read or flush clears it.
// - Transmit interrupt flag clears when software writes transmit data.
// - Transmit underflow sets flag; transmit data write clears it.
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_status_flags (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        addr_match_in,
  input  wire logic [1:0]  addr_id_in,
  input  wire logic        stop_in,
  input  wire logic        gencall_in,
  input  wire logic [1:0]  gencall_type_in,
  input  wire logic        gencall_hw_byte_in,
  input  wire logic [7:0]  gencall_byte_in,
  input  wire logic        slave_active_in,
  input  wire logic        tx_request_in,
  input  wire logic        tx_fifo_empty_in,
  input  wire logic        rx_fifo_overflow_in,
  input  wire logic        rx_byte_in,
  input  wire logic [7:0]  rx_fifo_data_in,
  input  wire logic        tx_done_in,
  input  wire logic        tx_fifo_underflow_in,
  output logic             rx_push_out,
  output logic [7:0]       rx_push_data_out,
  output logic             rx_pop_out,
  output logic             rx_flush_out,
  output logic             tx_push_out,
  output logic [7:0]       tx_push_data_out,
  output logic [15:0]      config_out,
  output logic             soft_reset_out,
  output logic             irq_out
);

  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        rd_take;
  logic        status_read;
  logic        pend_read;
  logic        rx_data_read;
  logic        tx_data_write;
  logic        config_write;
  logic        gc_clear;
  logic        rx_flush;
  logic        gc_reset;
  logic        armed;
  logic        stop_set;
  logic        nack_set;
  logic [1:0]  id_code;
  logic [1:0]  gc_type;
  logic        stop_flag;
  logic        gc_irq;
  logic        busy;
  logic        nack;
  logic        rx_ovf;
  logic        rx_irq;
  logic        tx_irq;
  logic        tx_unf;
  logic [15:0] status_word;
  logic [15:0] events;
  logic [15:0] irq_pend;
  logic [15:0] irq_mask;
  logic [15:0] config_reg;
  logic [31:0] next_rdata;

  // The bus is never stalled by the flag logic, so every access completes.
  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign do_write          = aw_held && w_held && !s_axi_bvalid_out;
  assign rd_take           = s_axi_arvalid_in && s_axi_arready_out;

  assign status_read   = rd_take && (s_axi_araddr_in == i2c_status_pkg::OFS_STATUS);
  assign pend_read     = rd_take && (s_axi_araddr_in == i2c_status_pkg::OFS_IRQ_STATUS);
  assign rx_data_read  = rd_take && (s_axi_araddr_in == i2c_status_pkg::OFS_RX_DATA);
  assign tx_data_write = do_write && (aw_addr == i2c_status_pkg::OFS_TX_DATA) && w_strb[0];
  assign config_write  = do_write && (aw_addr == i2c_status_pkg::OFS_CONFIG);
  assign gc_clear      = config_write && w_strb[1] && w_data[i2c_status_pkg::CFG_GC_CLEAR];
  assign rx_flush      = config_write && w_strb[1] && w_data[i2c_status_pkg::CFG_RX_FLUSH];

  assign gc_reset = gencall_in && (gencall_type_in == i2c_status_pkg::GC_RESET_PROG);
  assign stop_set = stop_in && armed;
  assign nack_set = tx_request_in && tx_fifo_empty_in;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_in;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_in;
      w_strb <= s_axi_wstrb_in;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= i2c_status_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out  <= i2c_status_pkg::addr_mapped(aw_addr) ?
                          i2c_status_pkg::RESP_OKAY : i2c_status_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (s_axi_araddr_in)
      i2c_status_pkg::OFS_STATUS:     next_rdata[15:0] = status_word;
      i2c_status_pkg::OFS_RX_DATA:    next_rdata[7:0]  = rx_fifo_data_in;
      i2c_status_pkg::OFS_CONFIG:     next_rdata[15:0] = config_reg;
      i2c_status_pkg::OFS_IRQ_MASK:   next_rdata[15:0] = irq_mask;
      i2c_status_pkg::OFS_IRQ_STATUS: next_rdata[15:0] = irq_pend;
      default:                        next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= i2c_status_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out  <= next_rdata;
      s_axi_rresp_out  <= i2c_status_pkg::addr_mapped(s_axi_araddr_in) ?
                          i2c_status_pkg::RESP_OKAY : i2c_status_pkg::RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // Armed from address match until the stop, so a stop without a match sets nothing.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      armed <= 1'b0;
    end else if (stop_in) begin
      armed <= 1'b0;
    end else if (addr_match_in) begin
      armed <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      id_code <= 2'h0;
    end else if (addr_match_in) begin
      id_code <= addr_id_in;
    end else if (gc_reset) begin
      id_code <= 2'h0;
    end
  end

  // The type is kept until the next address phase replaces it.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gc_type <= i2c_status_pkg::GC_NONE;
    end else if (gencall_in) begin
      gc_type <= gencall_type_in;
    end else if (addr_match_in) begin
      gc_type <= i2c_status_pkg::GC_NONE;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stop_flag <= 1'b0;
    end else if (stop_set) begin
      stop_flag <= 1'b1;
    end else if (status_read || gc_reset) begin
      stop_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gc_irq <= 1'b0;
    end else if (gencall_in) begin
      gc_irq <= 1'b1;
    end else if (gc_clear) begin
      gc_irq <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy <= 1'b0;
    end else begin
      busy <= slave_active_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nack <= 1'b0;
    end else if (nack_set) begin
      nack <= 1'b1;
    end else if (status_read || gc_reset) begin
      nack <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_ovf <= 1'b0;
    end else if (rx_fifo_overflow_in) begin
      rx_ovf <= 1'b1;
    end else if (status_read || gc_reset) begin
      rx_ovf <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_irq <= 1'b0;
    end else if (rx_byte_in) begin
      rx_irq <= 1'b1;
    end else if (rx_data_read || rx_flush || gc_reset) begin
      rx_irq <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_irq <= 1'b0;
    end else if (tx_done_in) begin
      tx_irq <= 1'b1;
    end else if (tx_data_write || gc_reset) begin
      tx_irq <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_unf <= 1'b0;
    end else if (tx_fifo_underflow_in) begin
      tx_unf <= 1'b1;
    end else if (tx_data_write || gc_reset) begin
      tx_unf <= 1'b0;
    end
  end

  always_comb begin
    status_word = i2c_status_pkg::STATUS_RESET;
    status_word[i2c_status_pkg::BIT_ID_LO +: 2] = id_code;
    status_word[i2c_status_pkg::BIT_STOP]       = stop_flag;
    status_word[i2c_status_pkg::BIT_GC_LO +: 2] = gc_type;
    status_word[i2c_status_pkg::BIT_GC_IRQ]     = gc_irq;
    status_word[i2c_status_pkg::BIT_BUSY]       = busy;
    status_word[i2c_status_pkg::BIT_NACK]       = nack;
    status_word[i2c_status_pkg::BIT_RX_OVF]     = rx_ovf;
    status_word[i2c_status_pkg::BIT_RX_IRQ]     = rx_irq;
    status_word[i2c_status_pkg::BIT_TX_IRQ]     = tx_irq;
    status_word[i2c_status_pkg::BIT_TX_UNF]     = tx_unf;
  end

  always_comb begin
    events = 16'h0000;
    events[i2c_status_pkg::BIT_STOP]   = stop_set;
    events[i2c_status_pkg::BIT_GC_IRQ] = gencall_in;
    events[i2c_status_pkg::BIT_NACK]   = nack_set;
    events[i2c_status_pkg::BIT_RX_OVF] = rx_fifo_overflow_in;
    events[i2c_status_pkg::BIT_RX_IRQ] = rx_byte_in;
    events[i2c_status_pkg::BIT_TX_IRQ] = tx_done_in;
    events[i2c_status_pkg::BIT_TX_UNF] = tx_fifo_underflow_in;
  end

  // A read clears the sticky bits, but an event in the same cycle survives it.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_pend <= i2c_status_pkg::PEND_RESET;
    end else if (pend_read || gc_reset) begin
      irq_pend <= events;
    end else begin
      irq_pend <= irq_pend | events;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_mask <= i2c_status_pkg::MASK_RESET;
    end else if (gc_reset) begin
      irq_mask <= i2c_status_pkg::MASK_RESET;
    end else if (do_write && (aw_addr == i2c_status_pkg::OFS_IRQ_MASK)) begin
      irq_mask <= i2c_status_pkg::merge_strobe(irq_mask, w_data, w_strb);
    end
  end

  // Command bits 8 and 9 act once and are never stored, so they read back as zero.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      config_reg <= i2c_status_pkg::CONFIG_RESET;
    end else if (gc_reset) begin
      config_reg <= i2c_status_pkg::CONFIG_RESET;
    end else if (config_write) begin
      config_reg <= i2c_status_pkg::merge_strobe(config_reg, w_data, w_strb) &
                    i2c_status_pkg::CFG_STORE_MASK;
    end
  end

  assign config_out = config_reg;
  assign irq_out    = |(irq_pend & irq_mask);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_push_out      <= 1'b0;
      rx_push_data_out <= 8'h00;
    end else begin
      rx_push_out <= gencall_hw_byte_in;
      if (gencall_hw_byte_in) begin
        rx_push_data_out <= gencall_byte_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_push_out      <= 1'b0;
      tx_push_data_out <= 8'h00;
    end else begin
      tx_push_out <= tx_data_write;
      if (tx_data_write) begin
        tx_push_data_out <= w_data[7:0];
      end
    end
  end

  // Pulses to the FIFOs and engine are registered so they leave on clean edges.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_pop_out     <= 1'b0;
      rx_flush_out   <= 1'b0;
      soft_reset_out <= 1'b0;
    end else begin
      rx_pop_out     <= rx_data_read;
      rx_flush_out   <= rx_flush;
      soft_reset_out <= gc_reset;
    end
  end

endmodule : i2c_slave_status_flags
`default_nettype wire

//--- test/i2c_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_engine_model (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       go_in,
  input  wire logic [3:0] code_in,
  input  wire logic [1:0] arg_in,
  input  wire logic [7:0] data_in,
  output logic      [8:0] pulse_out,
  output logic            busy_out,
  output logic      [1:0] arg_out,
  output logic      [7:0] data_out
);
  // Codes 0 to 8 give a one-cycle event pulse; 9 and 10 raise and drop busy.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pulse_out <= 9'h000;
      busy_out  <= 1'b0;
      arg_out   <= 2'h0;
      data_out  <= 8'h00;
    end else begin
      pulse_out <= (go_in && code_in < 4'h9) ? (9'h001 << code_in) : 9'h000;
      if (go_in && code_in == 4'h9) begin
        busy_out <= 1'b1;
      end
      if (go_in && code_in == 4'ha) begin
        busy_out <= 1'b0;
      end
      // Qualifiers wander between events so a design that samples them late sees garbage.
      arg_out  <= go_in ? arg_in : ~arg_out;
      data_out <= go_in ? data_in : ~data_out;
    end
  end
endmodule : i2c_engine_model
`default_nettype wire

//--- test/i2c_slave_status_flags_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_status_checker (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic [7:0]  s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        addr_match_in,
  input wire logic [1:0]  addr_id_in,
  input wire logic        stop_in,
  input wire logic        gencall_in,
  input wire logic [1:0]  gencall_type_in,
  input wire logic        gencall_hw_byte_in,
  input wire logic [7:0]  gencall_byte_in,
  input wire logic        slave_active_in,
  input wire logic        tx_request_in,
  input wire logic        tx_fifo_empty_in,
  input wire logic        rx_fifo_overflow_in,
  input wire logic        rx_push_out,
  input wire logic [7:0]  rx_push_data_out,
  input wire logic        soft_reset_out
);
  logic       ar_status;
  logic [1:0] id_q;
  logic       armed_q;
  assign ar_status = s_axi_arvalid_in && s_axi_arready_out && (s_axi_araddr_in == i2c_status_pkg::OFS_STATUS);
  // Shadow of the identifier field; a general call reset wipes it unless a match lands with it.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      id_q <= 2'h0;
    end else if (addr_match_in) begin
      id_q <= addr_id_in;
    end else if (gencall_in && gencall_type_in == i2c_status_pkg::GC_RESET_PROG) begin
      id_q <= 2'h0;
    end
  end
  // A stop only counts after an address match since the previous stop.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= !stop_in && (armed_q || addr_match_in);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  id_decode_a: assert property (ar_status |=> s_axi_rdata_out[12:11] == $past(id_q))
    else $error("identifier field wrong");
  stop_flag_a: assert property (stop_in && armed_q ##1 ar_status |=> s_axi_rdata_out[10])
    else $error("stop flag missing");
  gc_type_a: assert property (gencall_in ##1 ar_status |=>
    s_axi_rdata_out[9:8] == $past(gencall_type_in, 2) && s_axi_rdata_out[7]) else $error("general call field wrong");
  soft_reset_a: assert property (gencall_in && gencall_type_in == i2c_status_pkg::GC_RESET_PROG |=> soft_reset_out)
    else $error("soft reset missing");
  hw_push_a: assert property (gencall_hw_byte_in |=> rx_push_out && rx_push_data_out == $past(gencall_byte_in))
    else $error("second byte not pushed");
  busy_follow_a: assert property (ar_status |=> s_axi_rdata_out[6] == $past(slave_active_in, 2))
    else $error("busy flag wrong");
  nack_set_a: assert property (tx_request_in && tx_fifo_empty_in ##1 ar_status |=> s_axi_rdata_out[5])
    else $error("no-ack flag missing");
  rx_ovf_a: assert property (rx_fifo_overflow_in ##1 ar_status |=> s_axi_rdata_out[4])
    else $error("overflow flag missing");
  cover property (gencall_in && gencall_type_in == i2c_status_pkg::GC_RESET_PROG);
  cover property (ar_status && slave_active_in);
  cover property (rx_push_out);
endmodule : i2c_status_checker
bind i2c_slave_status_flags i2c_status_checker i_i2c_status_checker (.clk_in, .resetn_in, .s_axi_araddr_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .addr_match_in, .addr_id_in, .stop_in, .gencall_in,
  .gencall_type_in, .gencall_hw_byte_in, .gencall_byte_in, .slave_active_in, .tx_request_in, .tx_fifo_empty_in,
  .rx_fifo_overflow_in, .rx_push_out, .rx_push_data_out, .soft_reset_out);
`default_nettype wire

//--- test/i2c_slave_status_flags_tb.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_status_flags_tb;
  logic        clk_in, resetn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
  logic        s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic        s_axi_rvalid_out, eng_go, irq_out;
  logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, rx_fifo_data_in, eng_data, eng_byte, rx_push_data_out;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, persist;
  logic [3:0]  s_axi_wstrb_in, eng_code;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, eng_arg, eng_argq, rresp, bresp;
  logic [8:0]  pulse;
  logic        busy, rx_push_out, rx_pop_out, rx_flush_out, tx_push_out;
  logic [7:0]  tx_seen, tx_push_data_out;
  logic [15:0] cfg;
  logic [31:0] rdat;
  int          failures, n_compared, n_fifo;
  localparam logic [3:0] CODES [5] = '{4'h5, 4'h4, 4'h6, 4'h7, 4'h8};
  localparam int         BITS [5]  = '{4, 5, 3, 2, 1};
  localparam logic [1:0] GCT [3]   = '{2'h2, 2'h3, 2'h1};

  i2c_engine_model i_i2c_engine_model (.clk_in, .resetn_in, .go_in(eng_go), .code_in(eng_code), .arg_in(eng_arg),
    .data_in(eng_data), .pulse_out(pulse), .busy_out(busy), .arg_out(eng_argq), .data_out(eng_byte));
  i2c_slave_status_flags i_i2c_slave_status_flags (.clk_in, .resetn_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
    .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .addr_match_in(pulse[0]), .addr_id_in(eng_argq),
    .stop_in(pulse[1]), .gencall_in(pulse[2]), .gencall_type_in(eng_argq), .gencall_hw_byte_in(pulse[3]),
    .gencall_byte_in(eng_byte), .slave_active_in(busy), .tx_request_in(pulse[4]), .tx_fifo_empty_in(!busy),
    .rx_fifo_overflow_in(pulse[5]), .rx_byte_in(pulse[6]), .rx_fifo_data_in, .tx_done_in(pulse[7]),
    .tx_fifo_underflow_in(pulse[8]), .rx_push_out, .rx_push_data_out, .rx_pop_out, .rx_flush_out,
    .tx_push_out, .tx_push_data_out, .config_out(cfg), .soft_reset_out(), .irq_out);

  // Pops and flushes are counted together; the last pushed transmit byte is kept.
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      n_fifo <= 0;
    end else begin
      n_fifo <= n_fifo + rx_pop_out + rx_flush_out;
      if (tx_push_out) tx_seen <= tx_push_data_out;
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= s;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (!s_axi_bvalid_out && n < 60);
    bresp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
    if (n >= 60) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!s_axi_rvalid_out && n < 60);
    rdat = s_axi_rdata_out;
    rresp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    if (n >= 60) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask : rchk

  // Event pulse reaches the design one edge after this task returns.
  task automatic ev(input logic [3:0] c, input logic [1:0] a);
    @(posedge clk_in);
    eng_go <= 1'b1;
    eng_code <= c;
    eng_arg <= a;
    @(posedge clk_in);
    eng_go <= 1'b0;
  endtask : ev

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    chk(32'h0, 32'h1);
    report_and_stop();
  end

  initial begin
    {resetn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 6'h00;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = 52'h0;
    {eng_go, eng_code, eng_arg, eng_data} = 15'h0;
    rx_fifo_data_in = 8'h5a;
    failures = 0;
    n_compared = 0;
    persist = 32'h0;
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    rchk(i2c_status_pkg::OFS_STATUS, 32'(i2c_status_pkg::STATUS_RESET));
    rchk(i2c_status_pkg::OFS_CONFIG, 32'(i2c_status_pkg::CONFIG_RESET));
    rchk(i2c_status_pkg::OFS_IRQ_MASK, 32'(i2c_status_pkg::MASK_RESET));
    rchk(8'h20, 32'h0);
    chk(32'(rresp), 32'(i2c_status_pkg::RESP_SLVERR));
    wr(8'h20, 32'h1, 4'h1);
    chk(32'(bresp), 32'(i2c_status_pkg::RESP_SLVERR));
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      ev(CODES[i], 2'h0);
      if (BITS[i] < 4) persist[BITS[i]] = 1'b1;
      rchk(i2c_status_pkg::OFS_STATUS, persist | (32'h1 << BITS[i]));
    end
    wr(i2c_status_pkg::OFS_TX_DATA, 32'h33, 4'h1);
    rchk(i2c_status_pkg::OFS_STATUS, 32'h8);
    chk(32'(tx_seen), 32'h33);
    chk(32'(bresp), 32'(i2c_status_pkg::RESP_OKAY));
    rchk(i2c_status_pkg::OFS_RX_DATA, 32'h5a);
    rchk(i2c_status_pkg::OFS_STATUS, 32'h0);
    chk(n_fifo, 32'h1);
    ev(4'h6, 2'h0);
    wr(i2c_status_pkg::OFS_CONFIG, 32'h200, 4'h2);
    rchk(i2c_status_pkg::OFS_STATUS, 32'h0);
    chk(n_fifo, 32'h2);
    ev(4'h9, 2'h0);
    rchk(i2c_status_pkg::OFS_STATUS, 32'h40);
    ev(4'h4, 2'h0);
    rchk(i2c_status_pkg::OFS_STATUS, 32'h40);
    ev(4'ha, 2'h0);
    rchk(i2c_status_pkg::OFS_STATUS, 32'h0);
    ev(4'h1, 2'h0);
    rchk(i2c_status_pkg::OFS_STATUS, 32'h0);
    $display("test flags done");
    for (int id = 0; id < 4; id++) begin
      ev(4'h0, 2'(id));
      ev(4'h1, 2'h0);
      rchk(i2c_status_pkg::OFS_STATUS, (32'(id) << 11) | 32'h400);
    end
    rchk(i2c_status_pkg::OFS_STATUS, 32'h1800);
    wr(i2c_status_pkg::OFS_CONFIG, 32'h3, 4'h1);
    chk(32'(cfg), 32'h3);
    wr(i2c_status_pkg::OFS_IRQ_MASK, 32'hff, 4'h3);
    persist = 32'h1800;
    for (int j = 0; j < 3; j++) begin
      ev(4'h2, GCT[j]);
      if (GCT[j] == i2c_status_pkg::GC_RESET_PROG) persist = 32'h0;
      rchk(i2c_status_pkg::OFS_STATUS, persist | (32'(GCT[j]) << 8) | 32'h80);
      wr(i2c_status_pkg::OFS_CONFIG, 32'h100, 4'h2);
      rchk(i2c_status_pkg::OFS_STATUS, persist | (32'(GCT[j]) << 8));
    end
    rchk(i2c_status_pkg::OFS_IRQ_MASK, 32'h0);
    chk(32'(cfg), 32'h0);
    eng_data <= 8'hc3;
    ev(4'h3, 2'h0);
    @(posedge clk_in);
    #1 chk(32'({rx_push_out, rx_push_data_out}), 32'h1c3);
    $display("test general call done");
    wr(i2c_status_pkg::OFS_IRQ_MASK, 32'h8, 4'h1);
    rd(i2c_status_pkg::OFS_IRQ_STATUS);
    chk(32'(irq_out), 32'h0);
    ev(4'h6, 2'h0);
    @(posedge clk_in);
    #1 chk(32'(irq_out), 32'h1);
    rchk(i2c_status_pkg::OFS_IRQ_STATUS, 32'h8);
    chk(32'(irq_out), 32'h0);
    wr(i2c_status_pkg::OFS_IRQ_MASK, 32'h0, 4'h1);
    ev(4'h6, 2'h0);
    @(posedge clk_in);
    #1 chk(32'(irq_out), 32'h0);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule : i2c_slave_status_flags_tb
`default_nettype wire
